// ==== dv/flash_link_chk.sv ====
// Purpose: link timing checks per opcode, beside the interface joining both ends
// Assumes: mode 0; opcode on one line unless quad mode is on
// Notes:   rises are counted per frame and saturate at 255
`timescale 1ns/1ps
module flash_link_chk (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       sclk,
  input wire logic       csN,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOe,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe,
  input wire logic [3:0] io
);
  logic       sclkQ, csQ, quad;
  logic [7:0] opQ, cnt;
  wire        rise = sclk & ~sclkQ;
  wire        opOk = cnt >= (quad ? 8'h02 : 8'h08);

  // opcode capture; quad is tracked or quad opcodes would decode as junk
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sclkQ, csQ, quad, opQ, cnt} <= '0;
    end else begin
      sclkQ <= sclk;
      csQ   <= csN;
      if (csN) cnt <= 8'h00;
      else if (rise && cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (rise && !csN && !opOk) opQ <= quad ? {opQ[3:0], io} : {opQ[6:0], io[0]};
      if (csN && !csQ && opOk) quad <= (opQ == 8'h38) | (quad & (opQ != 8'hFF));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_DESELECT_QUIET: assert property (csN && $past(csN) |-> devOe == 4'h0 && !sclk)
    else $error("device drives or clock runs while deselected");
  AST_READ_NO_DUMMY: assert property (!quad && opQ == 8'h03 && opOk && cnt < 8'h20 |-> !devOe[1])
    else $error("plain read drives before address ends");
  AST_READ_FIRST: assert property (!quad && opQ == 8'h03 && cnt == 8'h20 && rise |-> devOe[1])
    else $error("plain read data late");
  AST_FAST_DUMMY: assert property (!quad && opQ == 8'h0B && opOk && cnt < 8'h28 |-> !devOe[1])
    else $error("fast read drives during dummy");
  AST_FAST_FIRST: assert property (!quad && opQ == 8'h0B && cnt == 8'h28 && rise |-> devOe[1])
    else $error("fast read data not after eight dummies");
  // the drive starts three cycles after the last dummy rise, so only the next rise is held to it
  AST_WRAP_FIRST: assert property (!quad && opQ == 8'hEC && opOk && cnt <= 8'h14 |->
      ((cnt < 8'h14) ? devOe == 4'h0 : (!rise || devOe == 4'hF)))
    else $error("wrapped read drive not after six dummies");
  AST_QWRAP_FIRST: assert property (quad && opQ == 8'h0C && opOk && cnt <= 8'h0E |->
      ((cnt < 8'h0E) ? devOe == 4'h0 : (!rise || devOe == 4'hF)))
    else $error("quad wrapped read drive not after six dummies");
  AST_BPR_READ: assert property (!quad && opQ == 8'h72 && cnt == 8'h08 && rise |-> devOe[1])
    else $error("protection read data late");
  AST_WRITES_SILENT: assert property (!quad && opOk &&
      (opQ inside {8'h42, 8'h8D, 8'hE8, 8'h98, 8'hA5, 8'h85}) |-> devOe == 4'h0)
    else $error("device drives during a write frame");
endmodule

// ==== dv/flash_opcode_and_read_timing_table_bench.sv ====
// Purpose: both link ends joined; reads, protection, identifier area, FIFO stall
// Assumes: memData is a fixed function of memAddr
// Notes:   expected values queue before each frame; the monitor pops them
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failCount++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module flash_opcode_and_read_timing_table_bench;
  import flash_cmd_pkg::*;
  localparam logic [7:0] RD_OPS [3] = '{OP_READ, OP_FAST_READ, OP_WRAP_144};
  logic        ref_clk, reset_n, cmdValid, cmdReady, wrValid, wrReady, rdValid, rdReady;
  logic        busy, bprLocked, otpLocked, quadMode, otpWe, hold, wrHit;
  logic [7:0]  cmdOp, cmdLen, wrData, rdData, memData, otpData, exp8;
  logic [23:0] cmdAddr, memAddr, a;
  logic [15:0] bprBits, lockBits;
  logic [10:0] otpAddr;
  logic [18:0] exp19;
  logic [7:0]  rdQ[$], wq[$];
  logic [18:0] otpQ[$];
  int          failCount = 0, compares = 0, cycles = 0, n;

  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ 8'h3C;
  endfunction

  flash_link_if link ();
  flash_host_end flash_host_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .busy(busy));
  flash_dev_end flash_dev_end_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
    .memAddr(memAddr), .memData(memData), .bprBits(bprBits), .lockBits(lockBits),
    .bprLocked(bprLocked), .otpLocked(otpLocked), .quadMode(quadMode), .otpWe(otpWe),
    .otpAddr(otpAddr), .otpData(otpData));
  flash_link_chk flash_link_chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(link.sclk),
    .csN(link.csN), .hostOut(link.hostOut), .hostOe(link.hostOe), .devOut(link.devOut),
    .devOe(link.devOe), .io(link.io));

  assign memData = mem(memAddr);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // drivers and monitor
  // ----------------------------------------
  // write bytes stay offered while queued; random read stalls unless held
  always @(posedge ref_clk) begin
    wrHit = wrValid & wrReady;
    #2;
    if (wrHit) void'(wq.pop_front());
    wrValid = wq.size() != 0;
    wrData  = wrValid ? wq[0] : 8'h00;
    rdReady = !hold && ($urandom % 4 != 0);
  end

  // an empty queue gives x, so any unexpected result is a mismatch
  always @(posedge ref_clk) begin
    if (rdValid === 1'b1 && rdReady) begin
      exp8 = rdQ.size() != 0 ? rdQ.pop_front() : 'x;
      `CHK(rdData, exp8)
    end
    if (otpWe === 1'b1) begin
      exp19 = otpQ.size() != 0 ? otpQ.pop_front() : 'x;
      `CHK({otpAddr, otpData}, exp19)
    end
    cycles++;
    if (cycles == 30000) begin
      failCount++;
      conclude();
    end
  end

  task automatic issue(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] ln);
    cmdOp = op;
    cmdAddr = ad;
    cmdLen = ln;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #2;
    end
    @(posedge ref_clk);
    #2 cmdValid = 1'b0;
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] ln);
    issue(op, ad, ln);
    repeat (6000) if (cmdReady !== 1'b1) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    #2;
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, cmdValid, wrValid, rdReady, hold, cmdOp, cmdAddr, cmdLen, wrData} = '0;
    void'($urandom(32'h633F));
    repeat (5) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    foreach (RD_OPS[i]) repeat (2) begin
      a = 24'($urandom);
      n = 1 + $urandom % 8;
      for (int k = 0; k < n; k++)
        rdQ.push_back(mem(RD_OPS[i] == OP_WRAP_144 ? {a[23:3], 3'(a[2:0] + k)} : a + 24'(k)));
      run(RD_OPS[i], a, 8'(n));
    end
    $display("test reads done");
    wq = '{8'hA1, 8'h5C};
    run(OP_BPR_WRITE, 24'h0, 8'h02);
    `CHK(bprBits, 16'hA15C)
    rdQ = {rdQ, 8'hA1, 8'h5C, 8'hA1};
    run(OP_BPR_READ, 24'h0, 8'h03);
    run(OP_BPR_LOCKDOWN, 24'h0, 8'h00);
    wq = '{8'h00, 8'h00};
    run(OP_BPR_WRITE, 24'h0, 8'h02);
    run(OP_GLOBAL_UNPROT, 24'h0, 8'h00);
    `CHK({bprLocked, bprBits}, 17'h1A15C)
    wq = '{8'h80, 8'h01};
    run(OP_NV_LOCKDOWN, 24'h0, 8'h02);
    `CHK({lockBits, bprBits}, 32'h8001A15D)
    reset_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    `CHK({bprLocked, lockBits, bprBits}, 33'h0)
    wq = '{8'h00, 8'h03, 8'hFF, 8'hFF};
    run(OP_NV_LOCKDOWN, 24'h0, 8'h02);
    run(OP_BPR_WRITE, 24'h0, 8'h02);
    run(OP_GLOBAL_UNPROT, 24'h0, 8'h00);
    `CHK(bprBits, 16'h0003)
    $display("test protection done");
    a = 24'(8 + $urandom % 2040);
    otpQ.push_back({a[10:0], 8'h5A});
    wq = '{8'h5A};
    run(OP_OTP_PROGRAM, a, 8'h01);
    wq = '{8'h11};
    run(OP_OTP_PROGRAM, 24'h000007, 8'h01);
    run(OP_OTP_LOCKOUT, 24'h0, 8'h00);
    wq = '{8'h22};
    run(OP_OTP_PROGRAM, a, 8'h01);
    `CHK(otpLocked, 1'b1)
    $display("test identifier area done");
    run(OP_QUAD_ENABLE, 24'h0, 8'h00);
    a = 24'($urandom);
    for (int k = 0; k < 8; k++) rdQ.push_back(mem({a[23:3], 3'(a[2:0] + k)}));
    run(OP_WRAP_444, a, 8'h08);
    run(OP_QUAD_RESET, 24'h0, 8'h00);
    `CHK(quadMode, 1'b0)
    $display("test quad wrap done");
    hold = 1'b1;
    a = 24'($urandom);
    for (int k = 0; k < 40; k++) rdQ.push_back(mem(a + 24'(k)));
    issue(OP_READ, a, 8'd40);
    repeat (2000) @(posedge ref_clk);
    #2;
    `CHK({busy, rdValid}, 2'b11)
    hold = 1'b0;
    run(OP_NO_POWERDOWN, 24'h0, 8'h00);
    `CHK(rdQ.size() + otpQ.size(), 0)
    $display("test fifo stall done");
    conclude();
  end
endmodule

// ==== verilog/byte_fifo.sv ====
// Purpose: valid/ready FIFO for received read bytes
// Assumes: DEPTH is a power of two
// Notes:   pointers carry one extra bit so full and empty are exact
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } fifo_t;

  fifo_t            s_q;
  fifo_t            s_d;
  logic [WIDTH-1:0] mem [DEPTH];

  assign inReady  = (s_q.wrPtr ^ s_q.rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = s_q.wrPtr != s_q.rdPtr;
  assign outData  = mem[s_q.rdPtr[AW-1:0]];

  // pointer moves on each accepted beat
  always_comb begin
    s_d = s_q;
    if (inValid && inReady) s_d.wrPtr = s_q.wrPtr + 1'b1;
    if (outValid && outReady) s_d.rdPtr = s_q.rdPtr + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge ref_clk) begin
    if (inValid && inReady) mem[s_q.wrPtr[AW-1:0]] <= inData;
  end
endmodule

// ==== verilog/flash_cmd_pkg.sv ====
// Purpose: shared opcodes, phase plans and timing counts for both link ends
// Assumes: mode-0 serial link, opcode then address, dummy and data phases
// Notes:   every phase length is counted in serial clocks
package flash_cmd_pkg;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_WRAP_144     = 8'hEC;
  localparam logic [7:0] OP_WRAP_444     = 8'h0C;
  localparam logic [7:0] OP_BPR_READ     = 8'h72;
  localparam logic [7:0] OP_BPR_WRITE    = 8'h42;
  localparam logic [7:0] OP_BPR_LOCKDOWN = 8'h8D;
  localparam logic [7:0] OP_NV_LOCKDOWN  = 8'hE8;
  localparam logic [7:0] OP_GLOBAL_UNPROT = 8'h98;
  localparam logic [7:0] OP_OTP_PROGRAM  = 8'hA5;
  localparam logic [7:0] OP_OTP_LOCKOUT  = 8'h85;
  localparam logic [7:0] OP_QUAD_ENABLE  = 8'h38;
  localparam logic [7:0] OP_QUAD_RESET   = 8'hFF;
  // power-down entry and release are reported as FFH, the same code as OP_QUAD_RESET
  localparam logic [7:0] OP_NO_POWERDOWN = 8'hFF;

  // ----------------------------------------
  // phase lengths and sizes
  // ----------------------------------------
  localparam logic [4:0] DUMMY_READ     = 5'h00;
  localparam logic [4:0] DUMMY_FAST     = 5'h08;
  localparam logic [4:0] DUMMY_WRAP_144 = 5'h06;
  localparam logic [4:0] DUMMY_WRAP_444 = 5'h06;
  localparam logic [4:0] CLK_BYTE_1     = 5'h08;
  localparam logic [4:0] CLK_BYTE_4     = 5'h02;
  localparam logic [4:0] CLK_ADDR_1     = 5'h18;
  localparam logic [4:0] CLK_ADDR_4     = 5'h06;
  localparam int         BPR_BITS       = 16;
  localparam int         OTP_AW         = 11;
  localparam logic [10:0] OTP_USER_FIRST = 11'h008;
  localparam logic [1:0] SCLK_DIV_LAST  = 2'h1;
  localparam int         FIFO_WIDTH     = 8;
  localparam int         FIFO_DEPTH     = 32;

  typedef enum logic [1:0] {DIR_NONE, DIR_READ, DIR_WRITE} dir_t;
  typedef enum logic [2:0] {PH_IDLE, PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_END} phase_t;
  typedef struct packed {
    logic       addr;
    logic       wide;
    logic [4:0] dummy;
    dir_t       dir;
    logic       wrap;
    logic       bprSrc;
  } plan_t;

  // decode an opcode into its phase plan; no plan carries mode bits
  function automatic plan_t planOf(input logic [7:0] op, input logic quad);
    plan_t p;
    p = '{addr: 1'b0, wide: quad, dummy: DUMMY_READ, dir: DIR_NONE, wrap: 1'b0,
          bprSrc: 1'b0};
    case (op)
      OP_READ:        begin p.addr = 1'b1; p.dir = DIR_READ; end
      OP_FAST_READ:   begin p.addr = 1'b1; p.dir = DIR_READ; p.dummy = DUMMY_FAST; end
      OP_WRAP_144:    begin p.addr = 1'b1; p.dir = DIR_READ; p.wide = 1'b1;
                            p.dummy = DUMMY_WRAP_144; p.wrap = 1'b1; end
      OP_WRAP_444:    begin p.addr = 1'b1; p.dir = DIR_READ; p.wide = 1'b1;
                            p.dummy = DUMMY_WRAP_444; p.wrap = 1'b1; end
      OP_BPR_READ:    begin p.dir = DIR_READ; p.bprSrc = 1'b1; end
      OP_BPR_WRITE:   p.dir = DIR_WRITE;
      OP_NV_LOCKDOWN: p.dir = DIR_WRITE;
      OP_OTP_PROGRAM: begin p.addr = 1'b1; p.dir = DIR_WRITE; end
      default:        p.dir = DIR_NONE;
    endcase
    return p;
  endfunction

  function automatic logic [4:0] byteClocks(input logic wide);
    return wide ? CLK_BYTE_4 : CLK_BYTE_1;
  endfunction

  // phase after the one ending; more is low when no data bytes are wanted
  function automatic phase_t nextPhase(input phase_t from, input plan_t p, input logic more);
    phase_t nx;
    nx = PH_END;
    if (from == PH_OPC && p.addr) nx = PH_ADDR;
    else if (from != PH_DUMMY && from != PH_DATA && p.dummy != 5'h00 && p.addr) nx = PH_DUMMY;
    else if (from != PH_DATA && p.dir != DIR_NONE && more) nx = PH_DATA;
    return nx;
  endfunction

  function automatic logic [4:0] phaseClocks(input phase_t ph, input plan_t p);
    logic [4:0] c;
    c = 5'h01;
    case (ph)
      PH_ADDR:  c = p.wide ? CLK_ADDR_4 : CLK_ADDR_1;
      PH_DUMMY: c = p.dummy;
      PH_DATA:  c = byteClocks(p.wide);
      default:  c = 5'h01;
    endcase
    return c;
  endfunction

endpackage

// ==== verilog/flash_dev_end.sv ====
// Purpose: device end that decodes flash opcodes and serves their phases
// Assumes: link signals come from logic on ref_clk, so no synchronisers
// Notes:   array bytes arrive on memData for the address on memAddr
`timescale 1ns/1ps
module flash_dev_end (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  flash_link_if.device     link,
  output logic [23:0]      memAddr,
  input  wire logic [7:0]  memData,
  output logic [flash_cmd_pkg::BPR_BITS-1:0] bprBits,
  output logic [flash_cmd_pkg::BPR_BITS-1:0] lockBits,
  output logic             bprLocked,
  output logic             otpLocked,
  output logic             quadMode,
  output logic             otpWe,
  output logic [flash_cmd_pkg::OTP_AW-1:0] otpAddr,
  output logic [7:0]       otpData
);
  import flash_cmd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    phase_t                 st;
    logic                   sclkPrev;
    logic                   quad;
    logic [7:0]             op;
    plan_t                  plan;
    logic [4:0]             cnt;
    logic [7:0]             sh;
    logic [23:0]            addr;
    logic [3:0]             ioOut;
    logic [3:0]             ioOe;
    logic [BPR_BITS-1:0]    bpr;
    logic [BPR_BITS-1:0]    nvl;
    logic                   bprLock;
    logic                   otpLock;
    logic                   otpWe;
    logic [OTP_AW-1:0]      otpAddr;
    logic [7:0]             otpData;
  } dev_t;

  localparam dev_t DEV_RESET = '{st: PH_OPC, cnt: CLK_BYTE_1, default: '0};

  dev_t       s_q;
  dev_t       s_d;
  logic       rise;
  logic       fall;
  logic       inWide;
  logic       isRead;
  logic [7:0] shIn;
  logic [7:0] fetch;
  logic [7:0] b;
  logic [4:0] byteClk;
  logic       otpUser;
  plan_t      pNew;

  assign link.devOut = s_q.ioOut;
  assign link.devOe  = s_q.ioOe;
  assign memAddr     = s_q.addr;
  assign bprBits     = s_q.bpr;
  assign lockBits    = s_q.nvl;
  assign bprLocked   = s_q.bprLock;
  assign otpLocked   = s_q.otpLock;
  assign quadMode    = s_q.quad;
  assign otpWe       = s_q.otpWe;
  assign otpAddr     = s_q.otpAddr;
  assign otpData     = s_q.otpData;

  // ----------------------------------------
  // serial clock edges and shared terms
  // ----------------------------------------
  // edges are seen one ref_clk after the host moves sclk; the host's
  // half period of two cycles leaves room for that lag
  always_comb begin
    rise    = link.sclk & ~s_q.sclkPrev;
    fall    = ~link.sclk & s_q.sclkPrev;
    inWide  = (s_q.st == PH_OPC) ? s_q.quad : s_q.plan.wide;
    shIn    = inWide ? {s_q.sh[3:0], link.io} : {s_q.sh[6:0], link.io[0]};
    pNew    = planOf(shIn, s_q.quad);
    byteClk = byteClocks(s_q.plan.wide);
    isRead  = s_q.st == PH_DATA && s_q.plan.dir == DIR_READ;
    // protection reads take byte 0 as the high half
    fetch   = s_q.plan.bprSrc ? (s_q.addr[0] ? s_q.bpr[7:0] : s_q.bpr[15:8])
                              : memData;
    // only the user part of the identifier area is programmable
    otpUser = s_q.addr[23:OTP_AW] == '0 && s_q.addr[OTP_AW-1:0] >= OTP_USER_FIRST;
  end

  // ----------------------------------------
  // command decoder and phase engine
  // ----------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.sclkPrev = link.sclk;
    s_d.otpWe    = 1'b0;
    b            = s_q.sh;
    if (link.csN) begin
      // deselect aborts any phase and frees the lines
      s_d.st   = PH_OPC;
      s_d.cnt  = byteClocks(s_q.quad);
      s_d.ioOe = 4'h0;
    end else if (rise) begin
      s_d.cnt = s_q.cnt - 5'h01;
      if (!isRead) s_d.sh = shIn;
      case (s_q.st)
        PH_OPC: if (s_q.cnt == 5'h01) begin
          s_d.op   = shIn;
          s_d.plan = pNew;
          s_d.addr = '0;
          // read phases follow the plan: no mode bits, dummy from table
          s_d.st   = nextPhase(PH_OPC, pNew, 1'b1);
          s_d.cnt  = phaseClocks(s_d.st, pNew);
          case (shIn)
            OP_BPR_LOCKDOWN:  s_d.bprLock = 1'b1;
            OP_OTP_LOCKOUT:   s_d.otpLock = 1'b1;
            // locked-down blocks keep their protection bit set
            OP_GLOBAL_UNPROT: if (!s_q.bprLock) s_d.bpr = s_q.nvl;
            OP_QUAD_ENABLE:   s_d.quad = 1'b1;
            // FFH only leaves quad mode; there is no power-down state
            OP_QUAD_RESET:    s_d.quad = 1'b0;
            default:          s_d.quad = s_q.quad;
          endcase
        end
        PH_ADDR: begin
          s_d.addr = inWide ? {s_q.addr[19:0], link.io} : {s_q.addr[22:0], link.io[0]};
          if (s_q.cnt == 5'h01) begin
            s_d.st  = nextPhase(PH_ADDR, s_q.plan, 1'b1);
            s_d.cnt = phaseClocks(s_d.st, s_q.plan);
          end
        end
        PH_DUMMY: if (s_q.cnt == 5'h01) begin
          // dummy count was loaded from the plan on entry
          s_d.st  = PH_DATA;
          s_d.cnt = byteClk;
        end
        PH_DATA: if (s_q.cnt == 5'h01) begin
          s_d.cnt  = byteClk;
          // wrapped bursts stay inside an aligned group of eight bytes
          s_d.addr = s_q.plan.wrap ? {s_q.addr[23:3], s_q.addr[2:0] + 3'h1}
                                   : s_q.addr + 24'h000001;
          if (s_q.plan.dir == DIR_WRITE) begin
            case (s_q.op)
              // bits under lock-down cannot be cleared by a write
              OP_BPR_WRITE: if (!s_q.bprLock) begin
                if (s_q.addr[0]) s_d.bpr[7:0] = shIn | s_q.nvl[7:0];
                else s_d.bpr[15:8] = shIn | s_q.nvl[15:8];
              end
              // lock-down bits only accumulate; they also force protection
              OP_NV_LOCKDOWN: if (s_q.addr[0]) begin
                s_d.nvl[7:0] = s_q.nvl[7:0] | shIn;
                s_d.bpr[7:0] = s_q.bpr[7:0] | shIn;
              end else begin
                s_d.nvl[15:8] = s_q.nvl[15:8] | shIn;
                s_d.bpr[15:8] = s_q.bpr[15:8] | shIn;
              end
              OP_OTP_PROGRAM: if (!s_q.otpLock && otpUser) begin
                s_d.otpWe   = 1'b1;
                s_d.otpAddr = s_q.addr[OTP_AW-1:0];
                s_d.otpData = shIn;
              end
              default: s_d.otpWe = 1'b0;
            endcase
          end
        end
        default: s_d.cnt = s_q.cnt;
      endcase
    end else if (fall && isRead) begin
      // a fresh byte is fetched on the fall before its first clock
      b          = (s_q.cnt == byteClk) ? fetch : s_q.sh;
      s_d.ioOut  = s_q.plan.wide ? b[7:4] : {2'b00, b[7], 1'b0};
      s_d.ioOe   = s_q.plan.wide ? 4'hF : 4'h2;
      s_d.sh     = s_q.plan.wide ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
    end
  end

  // lock flags and lock-down bits are volatile here: reset clears them
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) s_q <= DEV_RESET;
    else s_q <= s_d;
  end
endmodule

// ==== verilog/flash_host_end.sv ====
// Purpose: host end that runs one flash command frame per user request
// Assumes: serial clock is ref_clk divided by four, mode 0
// Notes:   read bytes pass through a FIFO; a full FIFO holds the clock
`timescale 1ns/1ps
module flash_host_end (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  flash_link_if.host       link,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [7:0]  cmdOp,
  input  wire logic [23:0] cmdAddr,
  input  wire logic [7:0]  cmdLen,
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [7:0]  wrData,
  output logic             rdValid,
  input  wire logic        rdReady,
  output logic [flash_cmd_pkg::FIFO_WIDTH-1:0] rdData,
  output logic             busy
);
  import flash_cmd_pkg::*;

  typedef struct packed {
    phase_t      st;
    logic [1:0]  div;
    logic        sclk;
    logic        csN;
    logic        quad;
    logic [7:0]  op;
    plan_t       plan;
    logic [4:0]  cnt;
    logic [7:0]  len;
    logic [7:0]  sh;
    logic [23:0] addr;
    logic [7:0]  rx;
    logic [3:0]  ioOut;
    logic [3:0]  ioOe;
    logic        push;
  } host_t;

  localparam host_t HOST_RESET = '{st: PH_IDLE, csN: 1'b1, default: '0};

  host_t      s_q;
  host_t      s_d;
  logic       tick;
  logic       rdPhase;
  logic       wrStart;
  logic       fifoReady;
  logic [4:0] byteClk;
  logic [7:0] rxNew;
  logic [7:0] b;

  assign link.sclk    = s_q.sclk;
  assign link.csN     = s_q.csN;
  assign link.hostOut = s_q.ioOut;
  assign link.hostOe  = s_q.ioOe;
  assign cmdReady     = s_q.st == PH_IDLE;
  assign busy         = s_q.st != PH_IDLE;

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.push = 1'b0;
    wrReady = 1'b0;
    b       = s_q.sh;
    tick    = s_q.div == SCLK_DIV_LAST;
    byteClk = byteClocks(s_q.plan.wide);
    rdPhase = s_q.st == PH_DATA && s_q.plan.dir == DIR_READ;
    wrStart = s_q.st == PH_DATA && s_q.plan.dir == DIR_WRITE && s_q.cnt == byteClk;
    rxNew   = s_q.plan.wide ? {s_q.rx[3:0], link.io} : {s_q.rx[6:0], link.io[1]};
    s_d.div = (s_q.st == PH_IDLE || tick) ? 2'h0 : s_q.div + 2'h1;
    if (s_q.st == PH_IDLE) begin
      if (cmdValid) begin
        // opcode width follows the quad flag; 0CH needs quad mode set first
        s_d.plan  = planOf(cmdOp, s_q.quad);
        s_d.op    = cmdOp;
        s_d.addr  = cmdAddr;
        s_d.len   = cmdLen;
        s_d.csN   = 1'b0;
        s_d.st    = PH_OPC;
        s_d.cnt   = byteClocks(s_q.quad);
        s_d.ioOut = s_q.quad ? cmdOp[7:4] : {3'b111, cmdOp[7]};
        s_d.ioOe  = s_q.quad ? 4'hF : 4'h1;
        s_d.sh    = s_q.quad ? {cmdOp[3:0], 4'h0} : {cmdOp[6:0], 1'b0};
      end
    end else if (tick && !s_q.sclk) begin
      // rising edge; a full FIFO holds the clock low during reads
      if (!(rdPhase && !fifoReady)) begin
        s_d.sclk = 1'b1;
        s_d.cnt  = s_q.cnt - 5'h01;
        if (rdPhase) s_d.rx = rxNew;
        if (s_q.cnt == 5'h01) begin
          if (s_q.st == PH_DATA) begin
            s_d.len  = s_q.len - 8'h01;
            s_d.cnt  = byteClk;
            s_d.push = rdPhase;
            if (s_q.len == 8'h01) s_d.st = PH_END;
          end else begin
            // dummy count comes from the plan, no mode-bit phase exists
            s_d.st  = nextPhase(s_q.st, s_q.plan, s_q.len != 8'h00);
            s_d.cnt = phaseClocks(s_d.st, s_q.plan);
          end
        end
      end
    end else if (tick && s_q.sclk) begin
      // falling edge; a write byte must be present before it goes out
      if (!(wrStart && !wrValid)) begin
        s_d.sclk = 1'b0;
        s_d.ioOe = 4'h0;
        case (s_q.st)
          PH_END: begin
            s_d.csN = 1'b1;
            s_d.st  = PH_IDLE;
            if (s_q.op == OP_QUAD_ENABLE) s_d.quad = 1'b1;
            if (s_q.op == OP_QUAD_RESET) s_d.quad = 1'b0;
          end
          PH_OPC: begin
            s_d.ioOut = s_q.quad ? s_q.sh[7:4] : {3'b111, s_q.sh[7]};
            s_d.ioOe  = s_q.quad ? 4'hF : 4'h1;
            s_d.sh    = s_q.quad ? {s_q.sh[3:0], 4'h0} : {s_q.sh[6:0], 1'b0};
          end
          PH_ADDR: begin
            s_d.ioOut = s_q.plan.wide ? s_q.addr[23:20] : {3'b111, s_q.addr[23]};
            s_d.ioOe  = s_q.plan.wide ? 4'hF : 4'h1;
            s_d.addr  = s_q.plan.wide ? {s_q.addr[19:0], 4'h0} : {s_q.addr[22:0], 1'b0};
          end
          PH_DATA: if (s_q.plan.dir == DIR_WRITE) begin
            b         = wrStart ? wrData : s_q.sh;
            wrReady   = wrStart;
            s_d.ioOut = s_q.plan.wide ? b[7:4] : {3'b111, b[7]};
            s_d.ioOe  = s_q.plan.wide ? 4'hF : 4'h1;
            s_d.sh    = s_q.plan.wide ? {b[3:0], 4'h0} : {b[6:0], 1'b0};
          end
          default: s_d.ioOe = 4'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) s_q <= HOST_RESET;
    else s_q <= s_d;
  end

  // readiness was checked at the edge that completed the byte
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .inValid  (s_q.push),
    .inReady  (fifoReady),
    .inData   (s_q.rx),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );
endmodule

// ==== verilog/flash_link_if.sv ====
// Purpose: serial flash link between the host end and the device end
// Assumes: both ends run on the same ref_clk; the link is level signals
// Notes:   io is resolved here from the two enables, idle lines read high
`timescale 1ns/1ps
interface flash_link_if;
  logic       sclk;
  logic       csN;
  logic [3:0] hostOut;
  logic [3:0] hostOe;
  logic [3:0] devOut;
  logic [3:0] devOe;
  logic [3:0] io;

  // ----------------------------------------
  // wire resolution, pull-up when nobody drives
  // ----------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_io
    assign io[i] = devOe[i] ? devOut[i] : (hostOe[i] ? hostOut[i] : 1'b1);
  end

  modport host (output sclk, output csN, output hostOut, output hostOe, input io);
  modport device (input sclk, input csN, input io, output devOut, output devOe);
endinterface
